/* File: rtl/sirm_top.v */
/*
 * system integrity reset monitor: reset sequencing onto the open-drain reset
 * pin, supply-warning flag and interrupt, clock-fail switch to backup clock.
 * assumes analog comparators, pll and clock detector outside, cpu clock is
 * clock_in, and the cpu supplies mode, mask and service-entry strobes.
 */
// Decided for this implementation: the address-and-strobe port and the register addresses.
`include "sirm_map.vh"

// Functional notes
// - drive reset pin low while the low-supply detector holds reset.
// - low-supply reset uses rising threshold when rising, falling when falling.
// - watchdog underflow pulls reset pin low for at least the minimum pulse.
// - illegal opcode or prebyte detection also resets the device.
// - option setting enables low-supply detector; disabled means no reset.
// - supply-warning flag is a real-time read-only status bit.
// - supply warning works only when low-supply detector is enabled.
// - with enable set, every warning flag toggle requests an interrupt.
// - no warning interrupt for a crossing during the post-reset delay.
// - setting enable while flag is high raises one interrupt itself.
// - enabling after the rising crossing gives exactly one interrupt.
// - backup pll enabled by option or by software bit.
// - on main clock loss with pll enabled, keep running from pll.
// - without an input clock at start-up, stay held in reset.
// - switch to backup sets clock-fail flag; interrupt only if enabled.
// - wait mode unchanged; both interrupts wake from wait.
// - halt freezes status; full halt also disables clock safety; resumes on wake.
// - supply warning stays active in halt and wakes from halt.
// - interrupt reaches cpu only when enabled and global mask cleared.
// - clock-fail interrupt wakes active-halt but not full halt.
// - every reset followed by 256 or 4096 cycle delay by option.
// - pending warning interrupt clears on service routine entry.
// - clock-fail flag cleared by status read after recovery; zero without pll.
// - watchdog flag set by watchdog reset, cleared by zero write or lvd reset.
module sirm_top
#(
   parameter DELAY_SHORT = `SIRM_DELAY_SHORT,
   parameter DELAY_LONG  = `SIRM_DELAY_LONG,
   parameter WDG_PULSE   = `SIRM_WDG_PULSE_CYC
)
(
   // clock and reset
   input  wire                    clock_in,
   input  wire                    nrst_in,
   // register port
   input  wire [`SIRM_ADDR_W-1:0] reg_addr_in,
   input  wire [7:0]              reg_wdata_in,
   input  wire                    reg_wr_in,
   input  wire                    reg_rd_in,
   output reg  [7:0]              reg_rdata_out,
   // option settings
   input  wire                    lvd_option_in,
   input  wire                    long_delay_opt_in,
   input  wire                    pll_option_in,
   // analog and clock detector, asynchronous
   input  wire                    below_rise_thr_in,
   input  wire                    below_fall_thr_in,
   input  wire                    supply_warn_cmp_in,
   input  wire                    clock_lost_in,
   input  wire                    osc_present_in,
   // reset pin, open drain
   input  wire                    reset_pin_in,
   output reg                     reset_pin_out,
   output reg                     reset_pin_oe_out,
   // cpu side
   input  wire                    wdg_underflow_in,
   input  wire                    illegal_op_in,
   input  wire                    irq_mask_in,
   input  wire                    wait_mode_in,
   input  wire                    halt_mode_in,
   input  wire                    active_halt_in,
   input  wire                    warn_isr_enter_in,
   input  wire                    cfail_isr_enter_in,
   output reg                     cpu_reset_out,
   output reg                     warn_irq_out,
   output reg                     cfail_irq_out,
   output reg                     wake_out,
   // clock control
   output reg                     pll_enable_out,
   output reg                     backup_clk_sel_out
);

////////////////////////////////////////////////////////////////////////////////
// input synchronisation

wire [5:0] sync_w;
wire       below_rise;
wire       below_fall;
wire       warn_cmp;
wire       clk_lost;
wire       osc_ok;
wire       pin_high;

sirm_sync2 #(.W(6)) u_sync
(
   .clock_in (clock_in),
   .nrst_in  (nrst_in),
   .async_in ({reset_pin_in, osc_present_in, clock_lost_in,
               supply_warn_cmp_in, below_fall_thr_in, below_rise_thr_in}),
   .sync_out (sync_w)
);

assign below_rise = sync_w[0];
assign below_fall = sync_w[1];
assign warn_cmp   = sync_w[2];
assign clk_lost   = sync_w[3];
assign osc_ok     = sync_w[4];
assign pin_high   = sync_w[5];

////////////////////////////////////////////////////////////////////////////////
// state

reg [1:0] state_q;
reg [1:0] state_d;
reg       lvd_rst_q;
reg       osc_seen_q;
reg [1:0] guard_q;
reg       lvd_flag_q;
reg       wdg_flag_q;
reg       warn_ie_q;
reg       warn_prev_q;
reg       warn_pend_q;
reg       cfail_ie_q;
reg       cfail_flag_q;
reg       cfail_pend_q;
reg       pll_sw_q;
reg       backup_q;

wire      wr_st  = reg_wr_in && (reg_addr_in == `SIRM_REG_STATUS);
wire      wr_ck  = reg_wr_in && (reg_addr_in == `SIRM_REG_CLOCK);
wire      rd_st  = reg_rd_in && (reg_addr_in == `SIRM_REG_STATUS);
wire      run    = (state_q == `SIRM_S_RUN);
wire      full_halt = halt_mode_in && !active_halt_in;

////////////////////////////////////////////////////////////////////////////////
// reset sources

wire       pulse_busy;
wire       delay_busy;
wire       pulse_start = wdg_underflow_in || illegal_op_in;
wire       delay_start = (state_q == `SIRM_S_ACTIVE) && (state_d == `SIRM_S_DELAY);
wire [12:0] delay_lim  = long_delay_opt_in ? DELAY_LONG[12:0] : DELAY_SHORT[12:0];

sirm_timer #(.W(13)) u_pulse
(
   .clock_in (clock_in),
   .nrst_in  (nrst_in),
   .start_in (pulse_start),
   .limit_in (WDG_PULSE[12:0]),
   .busy_out (pulse_busy)
);

sirm_timer #(.W(13)) u_delay
(
   .clock_in (clock_in),
   .nrst_in  (nrst_in),
   .start_in (delay_start),
   .limit_in (delay_lim),
   .busy_out (delay_busy)
);

// our own drive reads back low, so the pin only counts once settled in run
wire ext_low = run && (guard_q == 2'h0) && !pin_high;

wire src_active = lvd_rst_q || pulse_busy || pulse_start || ext_low
                  || !osc_seen_q;

// hysteresis: rising threshold while held, falling one while running
always @(posedge clock_in)
begin
   if (!nrst_in)
      lvd_rst_q <= 1'b0;
   else if (!lvd_option_in)
      lvd_rst_q <= 1'b0;
   else if (lvd_rst_q)
      lvd_rst_q <= below_rise;
   else
      lvd_rst_q <= below_fall;
end

always @(posedge clock_in)
begin
   if (!nrst_in)
      osc_seen_q <= 1'b0;
   else if (osc_ok)
      osc_seen_q <= 1'b1;
end

////////////////////////////////////////////////////////////////////////////////
// reset sequencer

always @*
begin
   state_d = state_q;
   case (state_q)
      `SIRM_S_ACTIVE:
         if (!src_active)
            state_d = `SIRM_S_DELAY;
      `SIRM_S_DELAY:
         if (src_active)
            state_d = `SIRM_S_ACTIVE;
         else if (!delay_busy && !delay_start)
            state_d = `SIRM_S_RUN;
      `SIRM_S_RUN:
         if (src_active)
            state_d = `SIRM_S_ACTIVE;
      default:
         state_d = `SIRM_S_ACTIVE;
   endcase
end

always @(posedge clock_in)
begin
   if (!nrst_in)
   begin
      state_q <= `SIRM_S_ACTIVE;
      guard_q <= `SIRM_PIN_GUARD;
   end
   else
   begin
      state_q <= state_d;
      if (!run)
         guard_q <= `SIRM_PIN_GUARD;
      else if (guard_q != 2'h0)
         guard_q <= guard_q - 2'h1;
   end
end

////////////////////////////////////////////////////////////////////////////////
// reset flags, set wins over the software clear

always @(posedge clock_in)
begin
   if (!nrst_in)
   begin
      lvd_flag_q <= 1'b0;
      wdg_flag_q <= 1'b0;
   end
   else
   begin
      if (lvd_rst_q)
         lvd_flag_q <= 1'b1;
      else if (wr_st && !halt_mode_in && !reg_wdata_in[`SIRM_ST_LVD_RF])
         lvd_flag_q <= 1'b0;
      if (wdg_underflow_in)
         wdg_flag_q <= 1'b1;
      else if (lvd_rst_q)
         wdg_flag_q <= 1'b0;
      else if (wr_st && !halt_mode_in && !reg_wdata_in[`SIRM_ST_WDG_RF])
         wdg_flag_q <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// supply warning

wire warn_flag   = warn_cmp && lvd_option_in;
wire warn_toggle = run && lvd_option_in && (warn_flag != warn_prev_q);
wire warn_ie_set = wr_st && !halt_mode_in && !warn_ie_q
                   && reg_wdata_in[`SIRM_ST_AVD_IE] && warn_flag;

always @(posedge clock_in)
begin
   if (!nrst_in)
   begin
      warn_ie_q   <= 1'b0;
      warn_prev_q <= 1'b0;
      warn_pend_q <= 1'b0;
   end
   else
   begin
      // prev tracks during the delay, so a crossing there is swallowed
      warn_prev_q <= warn_flag;
      if (wr_st && !halt_mode_in)
         warn_ie_q <= reg_wdata_in[`SIRM_ST_AVD_IE];
      // toggles latch while disabled, so a late enable still reports one
      if (warn_toggle || warn_ie_set)
         warn_pend_q <= 1'b1;
      else if (warn_isr_enter_in || !lvd_option_in || !run)
         warn_pend_q <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// clock safety

wire pll_en   = pll_option_in || pll_sw_q;
wire css_live = pll_en && !full_halt;
wire cfail_ev = css_live && clk_lost && !backup_q;

always @(posedge clock_in)
begin
   if (!nrst_in)
   begin
      pll_sw_q     <= 1'b0;
      cfail_ie_q   <= 1'b0;
      backup_q     <= 1'b0;
      cfail_flag_q <= 1'b0;
      cfail_pend_q <= 1'b0;
   end
   else
   begin
      // halt keeps the configuration, so wake by interrupt resumes it
      if (wr_ck && !halt_mode_in)
         pll_sw_q <= reg_wdata_in[`SIRM_CK_PLL_EN];
      if (wr_st && !halt_mode_in)
         cfail_ie_q <= reg_wdata_in[`SIRM_ST_CSS_IE];
      backup_q <= css_live && clk_lost;
      if (!pll_en)
         cfail_flag_q <= 1'b0;
      else if (cfail_ev)
         cfail_flag_q <= 1'b1;
      else if (rd_st && !clk_lost && !halt_mode_in)
         cfail_flag_q <= 1'b0;
      if (cfail_ev && cfail_ie_q)
         cfail_pend_q <= 1'b1;
      else if (cfail_isr_enter_in || !cfail_ie_q || !pll_en)
         cfail_pend_q <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// outputs and read data

wire warn_req  = warn_pend_q && warn_ie_q;
wire cfail_req = cfail_pend_q && cfail_ie_q && pll_en;
wire wake_d    = wait_mode_in && (warn_req || cfail_req)
                 || full_halt && warn_req
                 || active_halt_in && (warn_req || cfail_req);

reg [7:0] rdata_d;

always @*
begin
   rdata_d = `SIRM_RD_ZERO;
   case (reg_addr_in)
      `SIRM_REG_STATUS:
      begin
         rdata_d[`SIRM_ST_AVD_IE]   = warn_ie_q;
         rdata_d[`SIRM_ST_AVD_FLAG] = warn_flag;
         rdata_d[`SIRM_ST_LVD_RF]   = lvd_flag_q;
         rdata_d[`SIRM_ST_CSS_IE]   = cfail_ie_q;
         rdata_d[`SIRM_ST_CSS_FLAG] = cfail_flag_q;
         rdata_d[`SIRM_ST_WDG_RF]   = wdg_flag_q;
      end
      `SIRM_REG_CLOCK:
      begin
         rdata_d[`SIRM_CK_PLL_EN] = pll_sw_q;
         rdata_d[`SIRM_CK_BACKUP] = backup_q;
      end
      default:
         rdata_d = `SIRM_RD_ZERO;
   endcase
end

always @(posedge clock_in)
begin
   if (!nrst_in)
   begin
      reg_rdata_out      <= `SIRM_RD_ZERO;
      reset_pin_out      <= 1'b0;
      reset_pin_oe_out   <= 1'b1;
      cpu_reset_out      <= 1'b1;
      warn_irq_out       <= 1'b0;
      cfail_irq_out      <= 1'b0;
      wake_out           <= 1'b0;
      pll_enable_out     <= 1'b0;
      backup_clk_sel_out <= 1'b0;
   end
   else
   begin
      reg_rdata_out      <= reg_rd_in ? rdata_d : `SIRM_RD_ZERO;
      reset_pin_out      <= 1'b0;
      // pin held low in the active phase and through the delay
      reset_pin_oe_out   <= !run || src_active;
      cpu_reset_out      <= !run || src_active;
      warn_irq_out       <= warn_req && !irq_mask_in;
      cfail_irq_out      <= cfail_req && !irq_mask_in;
      wake_out           <= wake_d;
      pll_enable_out     <= css_live;
      backup_clk_sel_out <= css_live && clk_lost;
   end
end

endmodule // sirm_top

/* File: rtl/sirm_map.vh */
/*
 * constants for the system integrity reset monitor: register map, field
 * positions, reset values and timing counts.
 * assumes a 125 MHz cpu clock and a byte-wide register port.
 */
`ifndef SIRM_MAP_VH
`define SIRM_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// clock
`define SIRM_CLK_PERIOD_NS     8

// post-reset delay in cpu cycles, short and long option
`define SIRM_DELAY_SHORT       256
`define SIRM_DELAY_LONG        4096

// least watchdog reset output pulse, in ns, and its count rounded up
`define SIRM_WDG_PULSE_NS      1000
`define SIRM_WDG_PULSE_CYC     ((`SIRM_WDG_PULSE_NS + `SIRM_CLK_PERIOD_NS - 1) / `SIRM_CLK_PERIOD_NS)

// cycles the pin read-back is ignored after the pin is released
`define SIRM_PIN_GUARD         2'h3

////////////////////////////////////////////////////////////////////////////////
// register map
`define SIRM_ADDR_W            2
`define SIRM_REG_STATUS        2'h0
`define SIRM_REG_CLOCK         2'h1

// integrity_control_status fields
`define SIRM_ST_AVD_IE         6
`define SIRM_ST_AVD_FLAG       5
`define SIRM_ST_LVD_RF         4
`define SIRM_ST_CSS_IE         2
`define SIRM_ST_CSS_FLAG       1
`define SIRM_ST_WDG_RF         0

// clock control fields
`define SIRM_CK_PLL_EN         3
`define SIRM_CK_BACKUP         1

`define SIRM_RD_ZERO           8'h00

////////////////////////////////////////////////////////////////////////////////
// sequencer states
`define SIRM_S_ACTIVE          2'h0
`define SIRM_S_DELAY           2'h1
`define SIRM_S_RUN             2'h2

`endif

/* File: rtl/sirm_sync2.v */
/*
 * two flip-flop synchroniser, one bit per lane.
 * assumes inputs are levels that stay for several clock cycles.
 */
module sirm_sync2
#(
   parameter W = 1
)
(
   // clock and reset
   input  wire         clock_in,
   input  wire         nrst_in,
   // data
   input  wire [W-1:0] async_in,
   output reg  [W-1:0] sync_out
);

reg [W-1:0] meta_q;

always @(posedge clock_in)
begin
   if (!nrst_in)
   begin
      meta_q   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
   end
   else
   begin
      meta_q   <= async_in;
      sync_out <= meta_q;
   end
end

endmodule // sirm_sync2

/* File: rtl/sirm_timer.v */
/*
 * down counter: a start pulse loads the limit, busy stays high until zero.
 * assumes limit is at least one.
 */
module sirm_timer
#(
   parameter W = 13
)
(
   // clock and reset
   input  wire         clock_in,
   input  wire         nrst_in,
   // control
   input  wire         start_in,
   input  wire [W-1:0] limit_in,
   output wire         busy_out
);

reg [W-1:0] cnt_q;

assign busy_out = (cnt_q != {W{1'b0}});

always @(posedge clock_in)
begin
   if (!nrst_in)
      cnt_q <= {W{1'b0}};
   else if (start_in)
      cnt_q <= limit_in;
   else if (busy_out)
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
end

endmodule // sirm_timer

/* File: dv/sirm_reset_line.sv */
/*
 * reset wire model: open-drain line with pull-up, shared by the monitor and
 * an external reset source. assumes both parties only ever pull low.
 */
module sirm_reset_line
(
   // pulls
   input  wire dev_oe_in,
   input  wire ext_low_in,
   // wire level
   output wire level_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // pull-up wins only while nobody pulls low, never a stale value
   assign level_out = !(dev_oe_in || ext_low_in);
endmodule // sirm_reset_line

/* File: dv/sirm_checker.sv */
/*
 * checker for sirm_top: reset pin, reset delay and interrupt relations.
 * assumes option inputs stay level while reset is pending.
 */
module sirm_checker
#(
   parameter DELAY_SHORT = 256,
   parameter DELAY_LONG  = 4096,
   parameter WDG_PULSE   = 125
)
(
   // clock and reset
   input wire clock_in,
   input wire nrst_in,
   // options and sources
   input wire lvd_option_in,
   input wire long_delay_opt_in,
   input wire below_rise_thr_in,
   input wire below_fall_thr_in,
   input wire osc_present_in,
   input wire wdg_underflow_in,
   input wire illegal_op_in,
   input wire irq_mask_in,
   input wire warn_isr_enter_in,
   // outputs watched
   input wire reset_pin_out,
   input wire reset_pin_oe_out,
   input wire cpu_reset_out,
   input wire warn_irq_out,
   input wire cfail_irq_out,
   input wire pll_enable_out,
   input wire backup_clk_sel_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!nrst_in);
   ////////////////////////////////////////////////////////////////////////////
   // length of the current cpu reset, saturation not needed for short runs
   logic [15:0] rst_cnt_q;
   always @(posedge clock_in)
   begin
      if (!nrst_in || !cpu_reset_out)
         rst_cnt_q <= 16'h0;
      else
         rst_cnt_q <= rst_cnt_q + 16'h1;
   end
   ////////////////////////////////////////////////////////////////////////////
   pin_open_drain_a: assert property (!reset_pin_out)
      else $error("reset pin driven high");
   lvd_fall_hold_a: assert property ((lvd_option_in && below_fall_thr_in)[*4] |=> reset_pin_oe_out)
      else $error("low supply without pin low");
   lvd_rise_hold_a: assert property ((cpu_reset_out && lvd_option_in && below_rise_thr_in)[*4] |=> cpu_reset_out)
      else $error("reset left below rising threshold");
   wdg_pulse_a: assert property (wdg_underflow_in |=> reset_pin_oe_out[*4])
      else $error("watchdog pulse too short");
   illegal_op_a: assert property (illegal_op_in |=> cpu_reset_out && reset_pin_oe_out)
      else $error("illegal opcode ignored");
   warn_option_a: assert property ($rose(warn_irq_out) |-> lvd_option_in)
      else $error("warning irq with detector off");
   no_osc_hold_a: assert property ((cpu_reset_out && !osc_present_in)[*3] |=> cpu_reset_out)
      else $error("started without clock");
   irq_mask_a: assert property (irq_mask_in && $past(irq_mask_in) |-> !warn_irq_out && !cfail_irq_out)
      else $error("irq seen while masked");
   reset_delay_a: assert property ($fell(cpu_reset_out) |->
      rst_cnt_q >= (long_delay_opt_in ? DELAY_LONG : DELAY_SHORT))
      else $error("reset delay too short");
   isr_clear_a: assert property (warn_isr_enter_in |-> ##2 !warn_irq_out)
      else $error("warning irq not cleared");
   backup_pll_a: assert property (backup_clk_sel_out |-> pll_enable_out)
      else $error("backup clock without pll");
endmodule // sirm_checker

bind sirm_top sirm_checker #(.DELAY_SHORT(DELAY_SHORT), .DELAY_LONG(DELAY_LONG), .WDG_PULSE(WDG_PULSE)) u_chk
(
   .clock_in(clock_in), .nrst_in(nrst_in), .lvd_option_in(lvd_option_in),
   .long_delay_opt_in(long_delay_opt_in), .below_rise_thr_in(below_rise_thr_in),
   .below_fall_thr_in(below_fall_thr_in), .osc_present_in(osc_present_in),
   .wdg_underflow_in(wdg_underflow_in), .illegal_op_in(illegal_op_in), .irq_mask_in(irq_mask_in),
   .warn_isr_enter_in(warn_isr_enter_in), .reset_pin_out(reset_pin_out), .reset_pin_oe_out(reset_pin_oe_out),
   .cpu_reset_out(cpu_reset_out), .warn_irq_out(warn_irq_out), .cfail_irq_out(cfail_irq_out),
   .pll_enable_out(pll_enable_out), .backup_clk_sel_out(backup_clk_sel_out)
);

/* File: dv/sirm_top_tb.sv */
/*
 * testbench for sirm_top: resets, supply warning, clock fail, register port.
 * assumes short delay counts (16/64) and a 4 cycle watchdog pulse.
 */
module sirm_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
`include "sirm_map.vh"
   logic       clock_in = 0, nrst_in = 0, wr = 0, rd = 0, ext_low = 0;
   logic [1:0] addr = 0;
   logic [7:0] wdata = 0, d;
   logic       lvd_opt = 1, long_opt = 0, pll_opt = 0, b_rise = 0, b_fall = 0, warn_cmp = 0, lost = 0, osc = 0;
   logic       wdg = 0, ill = 0, mask = 0, wmode = 0, hmode = 0, ahalt = 0, wisr = 0, cisr = 0;
   wire  [7:0] rdata;
   wire        pin, pin_o, oe, cpu_rst, wirq, cirq, wake, pll_en, bsel;
   int         errors = 0, compares = 0, cyc = 0, n = 0;
   localparam int DLY_S = 16, DLY_L = 64, PULSE = 4;

   always #4 clock_in = ~clock_in;

   sirm_top #(.DELAY_SHORT(DLY_S), .DELAY_LONG(DLY_L), .WDG_PULSE(PULSE)) dut
   (
      .clock_in(clock_in), .nrst_in(nrst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .lvd_option_in(lvd_opt),
      .long_delay_opt_in(long_opt), .pll_option_in(pll_opt), .below_rise_thr_in(b_rise),
      .below_fall_thr_in(b_fall), .supply_warn_cmp_in(warn_cmp), .clock_lost_in(lost),
      .osc_present_in(osc), .reset_pin_in(pin), .reset_pin_out(pin_o), .reset_pin_oe_out(oe),
      .wdg_underflow_in(wdg), .illegal_op_in(ill), .irq_mask_in(mask), .wait_mode_in(wmode),
      .halt_mode_in(hmode), .active_halt_in(ahalt), .warn_isr_enter_in(wisr),
      .cfail_isr_enter_in(cisr), .cpu_reset_out(cpu_rst), .warn_irq_out(wirq),
      .cfail_irq_out(cirq), .wake_out(wake), .pll_enable_out(pll_en), .backup_clk_sel_out(bsel)
   );

   sirm_reset_line u_line (.dev_oe_in(oe), .ext_low_in(ext_low), .level_out(pin));

   ////////////////////////////////////////////////////////////////////////////
   task print_verdict;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic ticks(input int n);
      repeat (n) @(posedge clock_in);
   endtask

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
      @(posedge clock_in);
      wr <= 1; addr <= a; wdata <= v;
      @(posedge clock_in);
      wr <= 0;
   endtask

   // read data stand only in the cycle after the strobe is taken
   task automatic rd_reg(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clock_in);
      rd <= 1; addr <= a;
      @(posedge clock_in);
      rd <= 0;
      #1 chk(rdata & m, e);
      @(posedge clock_in);
   endtask

   // bounded wait for the reset sequence to finish
   task automatic boot;
      for (n = 0; n < 400 && cpu_rst !== 1'b0; n++)
         @(posedge clock_in);
      chk(cpu_rst, 0);
   endtask

   always @(posedge clock_in)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(99));
      ticks(2);
      nrst_in <= 1;
      ticks(20);
      chk(cpu_rst, 1);
      osc <= 1;
      boot();
      rd_reg(`SIRM_REG_STATUS, 8'hFF, 8'h00);
      rd_reg(`SIRM_REG_CLOCK, 8'hFF, 8'h00);
      // warning flag, enable while high, service, toggle back
      warn_cmp <= 1;
      ticks(4);
      // drop the toggle's pending, so only the enable raises it
      @(posedge clock_in) wisr <= 1;
      @(posedge clock_in) wisr <= 0;
      wr_reg(`SIRM_REG_STATUS, 8'h40);
      rd_reg(`SIRM_REG_STATUS, 8'h60, 8'h60);
      chk(wirq, 1);
      @(posedge clock_in) wisr <= 1;
      @(posedge clock_in) wisr <= 0;
      ticks(2);
      chk(wirq, 0);
      warn_cmp <= 0;
      ticks(5);
      chk(wirq, 1);
      mask <= 1;
      wmode <= 1;
      ticks(3);
      chk(wirq, 0);
      chk(wake, 1);
      mask <= 0;
      wmode <= 0;
      @(posedge clock_in) wisr <= 1;
      @(posedge clock_in) wisr <= 0;
      // halt: write ignored, warning still wakes
      hmode <= 1;
      wr_reg(`SIRM_REG_STATUS, 8'h00);
      warn_cmp <= 1;
      ticks(5);
      chk(wirq, 1);
      chk(wake, 1);
      hmode <= 0;
      @(posedge clock_in) wisr <= 1;
      @(posedge clock_in) wisr <= 0;
      wr_reg(`SIRM_REG_STATUS, 8'h00);
      warn_cmp <= 0;
      ticks(4);
      wr_reg(`SIRM_REG_STATUS, 8'h40);
      ticks(3);
      chk(wirq, 1);
      @(posedge clock_in) wisr <= 1;
      @(posedge clock_in) wisr <= 0;
      ticks(2);
      chk(wirq, 0);
      wr_reg(`SIRM_REG_STATUS, 8'h00);
      // random flag levels and unmapped accesses
      for (int i = 0; i < 16; i++)
      begin
         d = $urandom;
         warn_cmp <= d[0];
         wr_reg({1'b1, d[1]}, d);
         ticks(4);
         rd_reg({1'b1, d[1]}, 8'hFF, 8'h00);
         rd_reg(`SIRM_REG_STATUS, 8'hFF, {2'h0, d[0], 5'h0});
      end
      warn_cmp <= 0;
      // watchdog reset
      @(posedge clock_in) wdg <= 1;
      @(posedge clock_in) wdg <= 0;
      #1 chk(oe, 1);
      chk(pin, 0);
      boot();
      rd_reg(`SIRM_REG_STATUS, 8'h11, 8'h01);
      wr_reg(`SIRM_REG_STATUS, 8'h00);
      rd_reg(`SIRM_REG_STATUS, 8'h01, 8'h00);
      // illegal opcode with long delay, warning toggle swallowed in the active phase
      wr_reg(`SIRM_REG_STATUS, 8'h40);
      long_opt <= 1;
      @(posedge clock_in) ill <= 1;
      @(posedge clock_in) ill <= 0;
      #1 chk(cpu_rst, 1);
      warn_cmp <= 1;
      boot();
      chk(n >= DLY_L + PULSE && n <= DLY_L + PULSE + 8, 1);
      chk(wirq, 0);
      long_opt <= 0;
      wr_reg(`SIRM_REG_STATUS, 8'h00);
      warn_cmp <= 0;
      ext_low <= 1;
      ticks(6);
      chk(cpu_rst, 1);
      ext_low <= 0;
      boot();
      // low supply reset, rising threshold keeps it held
      b_rise <= 1;
      b_fall <= 1;
      ticks(5);
      chk(oe, 1);
      b_fall <= 0;
      ticks(40);
      chk(oe, 1);
      b_rise <= 0;
      boot();
      rd_reg(`SIRM_REG_STATUS, 8'h11, 8'h10);
      // detector off by option
      lvd_opt <= 0;
      b_rise <= 1;
      b_fall <= 1;
      wr_reg(`SIRM_REG_STATUS, 8'h40);
      warn_cmp <= 1;
      ticks(40);
      chk(cpu_rst, 0);
      chk(wirq, 0);
      wr_reg(`SIRM_REG_STATUS, 8'h00);
      b_rise <= 0;
      b_fall <= 0;
      warn_cmp <= 0;
      ticks(4);
      lvd_opt <= 1;
      // clock fail with software pll enable
      wr_reg(`SIRM_REG_CLOCK, 8'h08);
      wr_reg(`SIRM_REG_STATUS, 8'h04);
      lost <= 1;
      ticks(6);
      chk(bsel, 1);
      chk(cirq, 1);
      rd_reg(`SIRM_REG_STATUS, 8'h02, 8'h02);
      lost <= 0;
      ticks(4);
      rd_reg(`SIRM_REG_STATUS, 8'h02, 8'h02);
      rd_reg(`SIRM_REG_STATUS, 8'h02, 8'h00);
      @(posedge clock_in) cisr <= 1;
      @(posedge clock_in) cisr <= 0;
      ticks(2);
      chk(cirq, 0);
      wr_reg(`SIRM_REG_CLOCK, 8'h00);
      ticks(2);
      chk(pll_en, 0);
      pll_opt <= 1;
      ticks(3);
      chk(pll_en, 1);
      // full halt stops clock safety, active halt keeps it and wakes
      wr_reg(`SIRM_REG_STATUS, 8'h04);
      hmode <= 1;
      lost <= 1;
      ticks(6);
      chk(pll_en, 0);
      chk(wake, 0);
      ahalt <= 1;
      ticks(4);
      chk(wake, 1);
      chk(cirq, 1);
      print_verdict();
   end
endmodule // sirm_top_tb
